// file: hdl/i2cwc_slave.sv
`timescale 1ns/100ps
`include "i2cwc_defs.svh"

// Contract
// - Answer only fixed address, alternate by build
// - No address bits from pins
// - General call is never acknowledged
// - Any start returns to address phase
// - Nine high bits give nack, then reset
// - Interface reset leaves wiper untouched
// - After stop, idle until next start
// - Write is address, command, data, all acked
// - Wiper updates during the data acknowledge
// - Interrupted data byte is discarded
// - Further data bytes each applied in turn
// - Data byte top bit is ignored
// - Non-zero command never writes the wiper
// - Read is write command, restart, read address
// - Drive SDA through all eight read bits
// - Non-zero command never returns the wiper
// - Stop or restart ends current command
// - Power-on loads wiper with mid-scale
// - Invalid command is still acked, as are its data bytes
// - Never stretch SCL

module i2cwc_slave
  import i2cwc_pkg::*;
#(
  parameter bit ALT_ADDR = 1'b0
)
(
  // Clock, reset, enable
  input  wire logic                      ref_clk,
  input  wire logic                      rst_n,
  input  wire logic                      clk_en,
  // Bus clock pin, open drain
  input  wire logic                      scl_i,
  output logic                           scl_o,
  output logic                           scl_oe,
  // Bus data pin, open drain
  input  wire logic                      sda_i,
  output logic                           sda_o,
  output logic                           sda_oe,
  // Wiper value to the resistor network
  output logic      [`I2CWC_WIPER_W-1:0] wiper
);

  // Own address is a build constant only
  localparam logic [`I2CWC_WIPER_W-1:0] SLV_ADDR =
    ALT_ADDR ? `I2CWC_ADDR_ALT : `I2CWC_ADDR_STD;

  i2cwc_fsm_t                r_reg;
  i2cwc_fsm_t                r_next;
  logic                      wr_en;
  logic [`I2CWC_BYTE_W-1:0]  rd_byte;
  logic [`I2CWC_BYTE_W-1:0]  rx_byte;
  logic [`I2CWC_BYTE_W-1:0]  tx_shift;
  logic                      byte_done;

  i2cwc_cond_if cond ();

  // Pin synchroniser and condition detector
  i2cwc_sync u_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .scl_i   (scl_i),
    .sda_i   (sda_i),
    .cond    (cond)
  );

  // Wiper storage
  i2cwc_wiper u_wiper (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .wr_en   (wr_en),
    .wr_data (r_reg.shift[`I2CWC_WIPER_W-1:0]),
    .wiper   (wiper)
  );

  // Helper terms for the engine
  assign rx_byte   = {r_reg.shift[`I2CWC_BYTE_W-2:0], cond.sda_s};
  assign tx_shift  = {r_reg.tx[`I2CWC_BYTE_W-2:0], 1'b0};
  assign byte_done = cond.scl_fall && (r_reg.cnt == `I2CWC_BYTE_BITS);
  assign rd_byte   = (r_reg.cmd == `I2CWC_CMD_WIPER) ?
                     {1'b0, wiper} : `I2CWC_READ_FILL;

  // Protocol engine: sample on SCL rise, drive on SCL fall
  always_comb
  begin
    r_next = r_reg;
    wr_en  = 1'b0;
    if (cond.start)
    begin
      // Start or restart aborts anything in progress
      r_next.st      = I2CWC_ST_ADDR;
      r_next.cnt     = '0;
      r_next.sda_low = 1'b0;
    end
    else if (cond.stop)
    begin
      r_next.st      = I2CWC_ST_IDLE;
      r_next.sda_low = 1'b0;
    end
    else
    begin
      case (r_reg.st)
        I2CWC_ST_IDLE,
        I2CWC_ST_IGNORE:
        begin
          // Released, waiting for a start
          r_next.sda_low = 1'b0;
        end
        I2CWC_ST_ADDR:
        begin
          if (cond.scl_rise)
          begin
            r_next.shift = rx_byte;
            r_next.cnt   = r_reg.cnt + 4'h1;
          end
          else if (byte_done)
          begin
            if (r_reg.shift[7:1] == `I2CWC_ADDR_GCALL)
              r_next.st = I2CWC_ST_IGNORE;
            else if (r_reg.shift[7:1] == SLV_ADDR)
            begin
              r_next.st      = I2CWC_ST_AACK;
              r_next.sda_low = 1'b1;
              r_next.rw      = r_reg.shift[0];
            end
            else
              r_next.st = I2CWC_ST_IGNORE;
          end
        end
        I2CWC_ST_AACK:
        begin
          if (cond.scl_fall)
          begin
            r_next.cnt = '0;
            if (r_reg.rw)
            begin
              // Read address: first bit goes out now
              r_next.st      = I2CWC_ST_RDATA;
              r_next.tx      = rd_byte;
              r_next.sda_low = ~rd_byte[7];
            end
            else
            begin
              r_next.st      = I2CWC_ST_CMD;
              r_next.sda_low = 1'b0;
            end
          end
        end
        I2CWC_ST_CMD:
        begin
          if (cond.scl_rise)
          begin
            r_next.shift = rx_byte;
            r_next.cnt   = r_reg.cnt + 4'h1;
          end
          else if (byte_done)
          begin
            r_next.cmd     = r_reg.shift;
            r_next.st      = I2CWC_ST_CACK;
            r_next.sda_low = 1'b1;
          end
        end
        I2CWC_ST_CACK,
        I2CWC_ST_WACK:
        begin
          // Release after the acknowledge, take another byte
          if (cond.scl_fall)
          begin
            r_next.st      = I2CWC_ST_WDATA;
            r_next.cnt     = '0;
            r_next.sda_low = 1'b0;
          end
        end
        I2CWC_ST_WDATA:
        begin
          if (cond.scl_rise)
          begin
            r_next.shift = rx_byte;
            r_next.cnt   = r_reg.cnt + 4'h1;
          end
          else if (byte_done)
          begin
            // Whole byte received: acknowledge, store only for the wiper command
            r_next.st      = I2CWC_ST_WACK;
            r_next.sda_low = 1'b1;
            wr_en = (r_reg.cmd == `I2CWC_CMD_WIPER);
          end
        end
        I2CWC_ST_RDATA:
        begin
          if (cond.scl_rise)
            r_next.cnt = r_reg.cnt + 4'h1;
          else if (byte_done)
          begin
            // Eighth bit clocked: release for master answer
            r_next.st      = I2CWC_ST_RACK;
            r_next.sda_low = 1'b0;
          end
          else if (cond.scl_fall)
          begin
            r_next.tx      = tx_shift;
            r_next.sda_low = ~tx_shift[7];
          end
        end
        I2CWC_ST_RACK:
        begin
          if (cond.scl_rise)
            r_next.nack = cond.sda_s;
          else if (cond.scl_fall)
          begin
            r_next.cnt = '0;
            if (r_reg.nack)
              r_next.st = I2CWC_ST_IGNORE;
            else
            begin
              // Master asked for one more byte
              r_next.st      = I2CWC_ST_RDATA;
              r_next.tx      = rd_byte;
              r_next.sda_low = ~rd_byte[7];
            end
          end
        end
        default:
        begin
          r_next.st      = I2CWC_ST_IDLE;
          r_next.sda_low = 1'b0;
        end
      endcase
    end
  end

  // State register, frozen while the enable is low
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      r_reg.st      <= I2CWC_ST_IDLE;
      r_reg.shift   <= '0;
      r_reg.cnt     <= '0;
      r_reg.rw      <= 1'b0;
      r_reg.cmd     <= `I2CWC_CMD_WIPER;
      r_reg.tx      <= '0;
      r_reg.sda_low <= 1'b0;
      r_reg.nack    <= 1'b0;
    end
    else if (clk_en)
      r_reg <= r_next;
  end

  // Open-drain pins: SDA only pulled low, SCL never driven
  assign sda_o  = 1'b0;
  assign sda_oe = r_reg.sda_low;
  assign scl_o  = 1'b0;
  assign scl_oe = 1'b0;

  a_start_rearm: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    cond.start && clk_en |=> r_reg.st == I2CWC_ST_ADDR && !sda_oe)
    else $error("start did not return to address phase");

  a_stop_idle: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    cond.stop && clk_en |=> r_reg.st == I2CWC_ST_IDLE && !sda_oe)
    else $error("stop did not return to idle");

  a_no_stretch: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !scl_oe)
    else $error("scl driven");

  a_passive_release: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (r_reg.st == I2CWC_ST_IDLE || r_reg.st == I2CWC_ST_IGNORE)
    |-> !sda_oe)
    else $error("sda driven while passive");

  a_gcall_nack: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && r_reg.st == I2CWC_ST_ADDR && byte_done && !cond.start
    && !cond.stop && r_reg.shift[7:1] == `I2CWC_ADDR_GCALL
    |=> r_reg.st == I2CWC_ST_IGNORE && !sda_oe)
    else $error("general call acknowledged");

  a_addr_ack: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && r_reg.st == I2CWC_ST_ADDR && byte_done && !cond.start
    && !cond.stop && r_reg.shift[7:1] == SLV_ADDR
    |=> r_reg.st == I2CWC_ST_AACK && sda_oe)
    else $error("own address not acknowledged");

  a_wiper_source: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    $changed(wiper) |-> $past(r_reg.st) == I2CWC_ST_WDATA
    && $past(r_reg.cmd) == `I2CWC_CMD_WIPER
    && r_reg.st == I2CWC_ST_WACK)
    else $error("wiper changed outside data acknowledge");

  a_wiper_low7: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    $changed(wiper) |-> wiper == $past(r_reg.shift[6:0]))
    else $error("wiper not low seven data bits");

  a_read_fill: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && r_reg.st == I2CWC_ST_AACK && cond.scl_fall && r_reg.rw
    && !cond.start && !cond.stop && r_reg.cmd != `I2CWC_CMD_WIPER
    |=> r_reg.tx == `I2CWC_READ_FILL)
    else $error("wiper returned for non-zero command");

  a_read_drive: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    r_reg.st == I2CWC_ST_RDATA |-> sda_oe == ~r_reg.tx[7])
    else $error("read bit not driven");

  a_nack_reset: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && r_reg.st == I2CWC_ST_RACK && cond.scl_fall && r_reg.nack
    && !cond.start && !cond.stop
    |=> r_reg.st == I2CWC_ST_IGNORE ##1 !sda_oe)
    else $error("nack did not reset interface");

endmodule

// file: inc/i2cwc_defs.svh
`ifndef I2CWC_DEFS_SVH
`define I2CWC_DEFS_SVH

// Fixed slave addresses, normal and alternate build
`define I2CWC_ADDR_STD   7'h2e
`define I2CWC_ADDR_ALT   7'h3e
// General call address
`define I2CWC_ADDR_GCALL 7'h00
// Wiper value after power-on or brown-out reset
`define I2CWC_WIPER_RST  7'h3f
// Read data returned for a non-zero command code
`define I2CWC_READ_FILL  8'hff
// Command code that selects the wiper register
`define I2CWC_CMD_WIPER  8'h00
// Bits per byte on the bus
`define I2CWC_BYTE_BITS  4'h8
// Widths
`define I2CWC_BYTE_W     8
`define I2CWC_WIPER_W    7
`define I2CWC_CNT_W      4

`endif

// file: inc/i2cwc_pkg.sv
`include "i2cwc_defs.svh"

package i2cwc_pkg;

  // Serial interface states, one-hot
  typedef enum logic [9:0] {
    I2CWC_ST_IDLE   = 10'h001,
    I2CWC_ST_ADDR   = 10'h002,
    I2CWC_ST_AACK   = 10'h004,
    I2CWC_ST_CMD    = 10'h008,
    I2CWC_ST_CACK   = 10'h010,
    I2CWC_ST_WDATA  = 10'h020,
    I2CWC_ST_WACK   = 10'h040,
    I2CWC_ST_RDATA  = 10'h080,
    I2CWC_ST_RACK   = 10'h100,
    I2CWC_ST_IGNORE = 10'h200
  } i2cwc_state_t;

  // Protocol engine state
  typedef struct packed {
    i2cwc_state_t                st;
    logic [`I2CWC_BYTE_W-1:0]    shift;
    logic [`I2CWC_CNT_W-1:0]     cnt;
    logic                        rw;
    logic [`I2CWC_BYTE_W-1:0]    cmd;
    logic [`I2CWC_BYTE_W-1:0]    tx;
    logic                        sda_low;
    logic                        nack;
  } i2cwc_fsm_t;

  // Pin synchroniser state
  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_p;
    logic sda_m;
    logic sda_s;
    logic sda_p;
  } i2cwc_sync_t;

  // Wiper storage state
  typedef struct packed {
    logic [`I2CWC_WIPER_W-1:0] wiper;
  } i2cwc_wip_t;

endpackage

// file: inc/i2cwc_cond_if.sv
`timescale 1ns/100ps

// Bus events found by the synchroniser
interface i2cwc_cond_if;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic sda_s;

  modport src (
    output scl_rise,
    output scl_fall,
    output start,
    output stop,
    output sda_s
  );

  modport dst (
    input  scl_rise,
    input  scl_fall,
    input  start,
    input  stop,
    input  sda_s
  );
endinterface

// file: hdl/i2cwc_sync.sv
`timescale 1ns/100ps

module i2cwc_sync
  import i2cwc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic   ref_clk,
  input  wire logic   rst_n,
  input  wire logic   clk_en,
  // Raw bus pins
  input  wire logic   scl_i,
  input  wire logic   sda_i,
  // Bus events
  i2cwc_cond_if.src   cond
);

  i2cwc_sync_t r_reg;
  i2cwc_sync_t r_next;

  // Two flops per pin, then one more for edges
  always_comb
  begin
    r_next       = r_reg;
    r_next.scl_m = scl_i;
    r_next.scl_s = r_reg.scl_m;
    r_next.scl_p = r_reg.scl_s;
    r_next.sda_m = sda_i;
    r_next.sda_s = r_reg.sda_m;
    r_next.sda_p = r_reg.sda_s;
  end

  // Idle bus reads high
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      r_reg <= '1;
    else if (clk_en)
      r_reg <= r_next;
  end

  // Edges and conditions, only from synchronised stages
  assign cond.scl_rise = r_reg.scl_s & ~r_reg.scl_p;
  assign cond.scl_fall = ~r_reg.scl_s & r_reg.scl_p;
  assign cond.start    = r_reg.scl_s & r_reg.scl_p
                         & r_reg.sda_p & ~r_reg.sda_s;
  assign cond.stop     = r_reg.scl_s & r_reg.scl_p
                         & ~r_reg.sda_p & r_reg.sda_s;
  assign cond.sda_s    = r_reg.sda_s;

endmodule

// file: hdl/i2cwc_wiper.sv
`timescale 1ns/100ps
`include "i2cwc_defs.svh"

module i2cwc_wiper
  import i2cwc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                      ref_clk,
  input  wire logic                      rst_n,
  input  wire logic                      clk_en,
  // Write strobe and data
  input  wire logic                      wr_en,
  input  wire logic [`I2CWC_WIPER_W-1:0] wr_data,
  // Stored wiper
  output logic      [`I2CWC_WIPER_W-1:0] wiper
);

  i2cwc_wip_t r_reg;
  i2cwc_wip_t r_next;

  // Load only on the strobe; protocol resets never reach here
  always_comb
  begin
    r_next = r_reg;
    if (wr_en)
      r_next.wiper = wr_data;
  end

  // Power-on value is mid-scale
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      r_reg.wiper <= `I2CWC_WIPER_RST;
    else if (clk_en)
      r_reg <= r_next;
  end

  assign wiper = r_reg.wiper;

  a_wiper_por: assert property (
    @(posedge ref_clk) $rose(rst_n) |-> wiper == `I2CWC_WIPER_RST)
    else $error("wiper not mid-scale after reset");

endmodule

// file: test/i2cwc_master.sv
`timescale 1ns/100ps

module i2cwc_master
(
  // Bus levels seen on the wires
  input  wire logic scl,
  input  wire logic sda,
  // Pull-down requests onto the wires
  output logic      scl_low,
  output logic      sda_low
);
  localparam int QTR = 40;

  // Bus released at start
  initial
  begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  // One bit, data set while low, sampled mid-high
  task automatic bit_io(input logic b, output logic s);
    sda_low = !b;
    #QTR;
    scl_low = 1'b0;
    #QTR;
    s = sda;
    #QTR;
    scl_low = 1'b1;
    #QTR;
  endtask

  // Start or repeated start
  task automatic bus_start;
    sda_low = 1'b0;
    #QTR;
    scl_low = 1'b0;
    #QTR;
    sda_low = 1'b1;
    #QTR;
    scl_low = 1'b1;
    #QTR;
  endtask

  // Stop; clock then stands high
  task automatic bus_stop;
    sda_low = 1'b1;
    #QTR;
    scl_low = 1'b0;
    #QTR;
    sda_low = 1'b0;
    #QTR;
  endtask

  // Byte out MSB first, acknowledge returned
  task automatic write_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask

  // Byte in MSB first, acknowledged unless last
  task automatic read_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, b[i]);
    bit_io(last, s);
  endtask

  // Recovery: start, nine ones, start, stop
  task automatic recover;
    logic s;
    bus_start;
    repeat (9) bit_io(1'b1, s);
    bus_start;
    bus_stop;
  endtask
endmodule

// file: test/i2cwc_slave_tb.sv
`timescale 1ns/100ps
`include "i2cwc_defs.svh"

module i2cwc_slave_tb;
  localparam logic [7:0] AW = {`I2CWC_ADDR_STD, 1'b0};
  localparam logic [7:0] AR = {`I2CWC_ADDR_STD, 1'b1};
  // Design side
  logic       ref_clk;
  logic       rst_n;
  logic       clk_en;
  logic       scl_o;
  logic       scl_oe;
  logic       sda_o;
  logic       sda_oe;
  logic [6:0] wiper;
  // Master side and wires
  logic       m_scl_low;
  logic       m_sda_low;
  wire logic  scl;
  wire logic  sda;
  int         errors;
  int         cmp_count;

  // Open-drain wires with pull-ups; a driven one leaves the pull-up
  assign scl = !((scl_oe & !scl_o) | m_scl_low);
  assign sda = !((sda_oe & !sda_o) | m_sda_low);

  // Clock
  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;

  i2cwc_slave #(.ALT_ADDR(1'b0)) i_dut (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .scl_i   (scl),
    .scl_o   (scl_o),
    .scl_oe  (scl_oe),
    .sda_i   (sda),
    .sda_o   (sda_o),
    .sda_oe  (sda_oe),
    .wiper   (wiper)
  );

  i2cwc_master i_master (
    .scl     (scl),
    .sda     (sda),
    .scl_low (m_scl_low),
    .sda_low (m_sda_low)
  );

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic give_verdict;
    if (errors == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Clock line never driven, looked at away from the launching edge
  always @(negedge ref_clk)
    if (rst_n === 1'b1 && scl_oe !== 1'b0)
      chk("scl_oe", 8'h00, {7'h00, scl_oe});

  // Address and command phases
  task automatic head(input logic [7:0] cmd);
    logic ack;
    i_master.bus_start;
    i_master.write_byte(AW, ack);
    chk("addr ack", 8'h01, {7'h00, ack});
    i_master.write_byte(cmd, ack);
    chk("cmd ack", 8'h01, {7'h00, ack});
  endtask

  task automatic do_write(input logic [7:0] cmd, input logic [7:0] d);
    logic ack;
    head(cmd);
    i_master.write_byte(d, ack);
    chk("data ack", 8'h01, {7'h00, ack});
    i_master.bus_stop;
  endtask

  task automatic do_read(input logic [7:0] cmd, input logic [7:0] e);
    logic       ack;
    logic [7:0] d;
    head(cmd);
    i_master.bus_start;
    i_master.write_byte(AR, ack);
    chk("read addr ack", 8'h01, {7'h00, ack});
    i_master.read_byte(1'b0, d);
    chk("read byte", e, d);
    i_master.read_byte(1'b1, d);
    chk("last read byte", e, d);
    i_master.bus_stop;
    chk("sda after stop", 8'h00, {7'h00, sda_oe});
  endtask

  task automatic t_writes;
    logic ack;
    chk("reset wiper", 8'h3f, {1'b0, wiper});
    do_write(8'h00, 8'hd5);
    chk("top bit dropped", 8'h55, {1'b0, wiper});
    head(8'h00);
    i_master.write_byte(8'h12, ack);
    chk("first of burst", 8'h12, {1'b0, wiper});
    i_master.write_byte(8'h6a, ack);
    chk("second of burst", 8'h6a, {1'b0, wiper});
    i_master.bus_stop;
  endtask

  task automatic t_reads;
    do_read(8'h00, 8'h6a);
    do_write(8'h01, 8'h00);
    chk("cmd 1 write", 8'h6a, {1'b0, wiper});
    do_read(8'h01, 8'hff);
  endtask

  task automatic t_foreign;
    logic [6:0] adr [2] = '{`I2CWC_ADDR_ALT, `I2CWC_ADDR_GCALL};
    logic       ack;
    foreach (adr[k])
    begin
      i_master.bus_start;
      i_master.write_byte({adr[k], 1'b0}, ack);
      chk("foreign ack", 8'h00, {7'h00, ack});
      i_master.write_byte(8'h00, ack);
      chk("ignored byte", 8'h00, {7'h00, ack});
      i_master.bus_stop;
    end
    chk("wiper kept", 8'h6a, {1'b0, wiper});
  endtask

  task automatic t_abort;
    logic s;
    head(8'h00);
    repeat (4) i_master.bit_io(1'b0, s);
    i_master.bus_stop;
    chk("cut by stop", 8'h6a, {1'b0, wiper});
    head(8'h00);
    repeat (4) i_master.bit_io(1'b0, s);
    do_write(8'h00, 8'h21);
    chk("after restart", 8'h21, {1'b0, wiper});
  endtask

  task automatic t_recover;
    logic ack;
    logic s;
    do_write(8'h00, 8'h80);
    chk("zero wiper", 8'h00, {1'b0, wiper});
    head(8'h00);
    i_master.bus_start;
    i_master.write_byte(AR, ack);
    repeat (2)
    begin
      i_master.bit_io(1'b1, s);
      chk("zero bit held", 8'h00, {7'h00, s});
    end
    i_master.recover;
    chk("sda freed", 8'h00, {7'h00, sda_oe});
    chk("wiper kept", 8'h00, {1'b0, wiper});
    do_write(8'h00, 8'h44);
    chk("after recovery", 8'h44, {1'b0, wiper});
  endtask

  // Frozen block ignores a whole frame
  task automatic t_freeze;
    logic ack;
    clk_en = 1'b0;
    i_master.bus_start;
    i_master.write_byte(AW, ack);
    chk("frozen ack", 8'h00, {7'h00, ack});
    i_master.write_byte(8'h00, ack);
    i_master.write_byte(8'h11, ack);
    i_master.bus_stop;
    clk_en = 1'b1;
    chk("frozen wiper", 8'h44, {1'b0, wiper});
  endtask

  task automatic t_reset;
    @(posedge ref_clk);
    #1 rst_n = 1'b0;
    repeat (8) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    chk("second reset", 8'h3f, {1'b0, wiper});
    repeat (4) @(posedge ref_clk);
    #1;
    do_write(8'h00, 8'h3a);
    chk("write after reset", 8'h3a, {1'b0, wiper});
  endtask

  // Hang guard
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    errors++;
    $display("CHECK FAILED run time expected end seen limit");
    give_verdict;
  end

  // Main sequence
  initial
  begin
    errors = 0;
    cmp_count = 0;
    clk_en = 1'b1;
    rst_n = 1'b0;
    repeat (8) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    t_writes;
    t_reads;
    t_foreign;
    t_abort;
    t_recover;
    t_freeze;
    t_reset;
    give_verdict;
  end
endmodule
